// ---- verification/rqdec_far_end.sv ----
// partner model: host descriptor queues and ring engine beside the decoder
module rqdec_far_end (
  input wire logic clock,          // system clock
  output logic desc_valid,         // part handed over
  output logic desc_chan,          // channel of the part
  output logic [31:0] desc_word0,  // descriptor word 0
  output logic [31:0] desc_word1,  // descriptor word 1
  output logic token_req,          // token request phase
  output logic token_chan,         // requesting channel
  output logic svc_end,            // end of service opportunity
  output logic req_done,           // request completed
  output logic [7:0] rx_fcb,       // received frame control byte
  output logic rx_valid            // received byte valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rpt_zero_ff = 1'b0;  // a repeat request sits on channel zero
  // idle values at time zero
  initial begin
    desc_valid = 1'b0;
    desc_chan = 1'b0;
    desc_word0 = 32'h0000_0000;
    desc_word1 = 32'h0000_0000;
    token_req = 1'b0;
    token_chan = 1'b0;
    svc_end = 1'b0;
    req_done = 1'b0;
    rx_fcb = 8'h00;
    rx_valid = 1'b0;
  end
  // one part per call, none on channel one while channel zero repeats; released words are inverted so stale data cannot pass
  task automatic load(input logic ch, input logic [1:0] tag, input logic [23:0] w0);
    if (ch && rpt_zero_ff) return;
    if (!ch) rpt_zero_ff = w0[15] && tag[1];
    @(posedge clock);
    desc_valid <= 1'b1;
    desc_chan <= ch;
    desc_word0 <= {8'h00, w0};
    desc_word1 <= {tag, 30'h0000_0000};
    @(posedge clock);
    desc_valid <= 1'b0;
    desc_word0 <= ~{8'h00, w0};
    desc_word1 <= ~{tag, 30'h0000_0000};
  endtask
  // ring engine raises or drops the token request of a channel
  task automatic token(input logic ch, input logic on);
    @(posedge clock);
    token_req <= on;
    token_chan <= ch;
  endtask
  // one completion or service end pulse
  task automatic ring_event(input logic done);
    @(posedge clock);
    req_done <= done;
    svc_end <= !done;
    @(posedge clock);
    req_done <= 1'b0;
    svc_end <= 1'b0;
  endtask
  // one received frame control byte
  task automatic rx_byte(input logic [7:0] b);
    @(posedge clock);
    rx_fcb <= b;
    rx_valid <= 1'b1;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_fcb <= ~b;
  endtask
endmodule

// ---- verification/rqdec_top_test.sv ----
// self-checking bench for the request descriptor decoder
module rqdec_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic ch;
    logic [1:0] tag;
    logic [23:0] w0;
    logic ab;
    logic cl;
    logic bc;
  } rqdec_row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic desc_valid, desc_chan, token_req, token_chan, svc_end, req_done, rx_valid;
  logic [31:0] desc_word0, desc_word1, rdata, rd;
  logic [7:0] rx_fcb, tx_fcb_ff, frame_count_ff;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, abort_ff, cnf_write_ff, cnf_full_ff;
  logic repeat_ff, rx_match_ff, claim_request_line, beacon_request_line;
  logic [1:0] bresp, rresp, cnf_status_ff, rsp;
  logic [3:0] ring_request_class_lines;
  int mismatches = 0, check_count = 0, cw_cnt = 0, rm_cnt = 0;
  logic [3:0] tk_exp [3] = '{4'h8, 4'h4, 4'h0};
  // part sequence: channel, tag, word 0 low bits, then abort, claim, beacon
  rqdec_row_t rows [10] = '{
    '{1'b0, 2'b11, 24'h05_11c3, 1'b0, 1'b1, 1'b0},
    '{1'b0, 2'b10, 24'h02_18c2, 1'b0, 1'b0, 1'b1},
    '{1'b0, 2'b00, 24'h03_0000, 1'b0, 1'b0, 1'b0},
    '{1'b0, 2'b01, 24'h00_0000, 1'b0, 1'b0, 1'b0},
    '{1'b0, 2'b00, 24'h01_00c3, 1'b1, 1'b0, 1'b0},
    '{1'b0, 2'b01, 24'h07_00c3, 1'b0, 1'b1, 1'b0},
    '{1'b0, 2'b10, 24'h01_10c2, 1'b1, 1'b1, 1'b0},
    '{1'b0, 2'b10, 24'h01_11c2, 1'b1, 1'b1, 1'b0},
    '{1'b1, 2'b10, 24'h04_1400, 1'b0, 1'b0, 1'b0},
    '{1'b0, 2'b01, 24'h06_00c2, 1'b0, 1'b0, 1'b1}};

  // 50 MHz clock
  always #10 clock = ~clock;
  // count one-cycle pulses; edge sampling sees the settled previous value
  always @(posedge clock) begin
    if (cnf_write_ff === 1'b1) cw_cnt++;
    if (rx_match_ff === 1'b1) rm_cnt++;
  end

  rqdec_far_end i_rqdec_far_end (.clock(clock), .desc_valid(desc_valid), .desc_chan(desc_chan),
    .desc_word0(desc_word0), .desc_word1(desc_word1), .token_req(token_req),
    .token_chan(token_chan), .svc_end(svc_end), .req_done(req_done), .rx_fcb(rx_fcb),
    .rx_valid(rx_valid));
  rqdec_top i_rqdec_top (.clock(clock), .rst_n(rst_n), .desc_valid(desc_valid),
    .desc_chan(desc_chan), .desc_word0(desc_word0), .desc_word1(desc_word1),
    .token_req(token_req), .token_chan(token_chan), .svc_end(svc_end), .req_done(req_done),
    .rx_fcb(rx_fcb), .rx_valid(rx_valid), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ring_request_class_lines(ring_request_class_lines),
    .claim_request_line(claim_request_line), .beacon_request_line(beacon_request_line),
    .tx_fcb_ff(tx_fcb_ff), .abort_ff(abort_ff), .cnf_status_ff(cnf_status_ff),
    .cnf_write_ff(cnf_write_ff), .cnf_full_ff(cnf_full_ff), .repeat_ff(repeat_ff),
    .frame_count_ff(frame_count_ff), .rx_match_ff(rx_match_ff), .irq(irq));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ready is sampled at the falling edge, the value the next rising edge sees
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge clock);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rsp = bresp;
      @(posedge clock);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(rsp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r) begin
      @(negedge clock);
      ar = arvalid && arready;
      r = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clock);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    axi_rd(rqdec_pkg::ADR_MASK);
    chk(rd, {28'h0000000, rqdec_pkg::RST_MASK});
    chk(irq, 1'b0);
    foreach (rows[i]) begin
      i_rqdec_far_end.load(rows[i].ch, rows[i].tag, rows[i].w0);
      #1;
      chk(abort_ff, rows[i].ab);
      chk(cnf_status_ff, {2{rows[i].ab}});
      chk({claim_request_line, beacon_request_line}, {rows[i].cl, rows[i].bc});
      if (!rows[i].ab) chk(frame_count_ff, rows[i].w0[23:16]);
    end
    $display("descriptor table done");
    // middle and bad parts must not overwrite the latched classes
    foreach (tk_exp[j]) begin
      i_rqdec_far_end.token(j[0], j < 2);
      repeat (2) @(posedge clock);
      #1;
      chk(ring_request_class_lines, tk_exp[j]);
    end
    axi_rd(rqdec_pkg::ADR_CLS0);
    chk(rd[17:8], 10'h118);
    axi_rd(rqdec_pkg::ADR_CLS1);
    chk(rd[17:8], 10'h214);
    $display("class latch done");
    // two confirm classes with opposite bits
    for (int k = 0; k < 2; k++) begin
      i_rqdec_far_end.load(1'b0, 2'b11, k ? 24'h00_a101 : 24'h00_5101);
      i_rqdec_far_end.token(1'b0, 1'b1);
      repeat (3) @(posedge clock);
      #1;
      chk(cnf_full_ff, !k);
      chk(repeat_ff, k);
      cw_cnt = 0;
      i_rqdec_far_end.ring_event(1'b1);
      repeat (3) @(posedge clock);
      chk(cw_cnt, !k);
      i_rqdec_far_end.ring_event(1'b0);
      repeat (3) @(posedge clock);
      chk(cw_cnt, 1);
      i_rqdec_far_end.token(1'b0, 1'b0);
    end
    $display("confirm class done");
    // transparency on, then off
    for (int k = 1; k >= 0; k--) begin
      axi_wr(rqdec_pkg::ADR_CTRL, k, rqdec_pkg::RESP_OK);
      i_rqdec_far_end.load(1'b0, 2'b11, 24'h00_11c3);
      #1;
      chk(tx_fcb_ff, k ? 8'h00 : 8'hc3);
      chk(claim_request_line, 1'b1);
      rm_cnt = 0;
      i_rqdec_far_end.rx_byte(8'hc3);
      i_rqdec_far_end.rx_byte(8'h55);
      repeat (3) @(posedge clock);
      chk(rm_cnt, !k);
    end
    $display("transparency done");
    // status, conflict, mask, clear and an unmapped address
    axi_rd(rqdec_pkg::ADR_STAT);
    chk(rd, 32'h1);
    chk(irq, 1'b1);
    axi_wr(rqdec_pkg::ADR_CTRL, 32'h4, rqdec_pkg::RESP_OK);
    i_rqdec_far_end.token(1'b1, 1'b1);
    repeat (3) @(posedge clock);
    i_rqdec_far_end.token(1'b1, 1'b0);
    axi_rd(rqdec_pkg::ADR_STAT);
    chk(rd, 32'h9);
    axi_wr(rqdec_pkg::ADR_MASK, 32'hf, rqdec_pkg::RESP_OK);
    repeat (2) @(posedge clock);
    #1;
    chk(irq, 1'b0);
    axi_wr(rqdec_pkg::ADR_STAT, 32'h9, rqdec_pkg::RESP_OK);
    axi_rd(rqdec_pkg::ADR_STAT);
    chk(rd, 32'h0);
    axi_wr(rqdec_pkg::ADR_MASK, 32'h0, rqdec_pkg::RESP_OK);
    axi_wr(rqdec_pkg::ADR_CTRL, 32'h0, rqdec_pkg::RESP_OK);
    axi_rd(8'h20);
    chk(rsp, rqdec_pkg::RESP_ERR);
    chk(rd, 32'h0);
    axi_wr(8'h20, 32'h1, rqdec_pkg::RESP_ERR);
    $display("registers done");
    // reset in mid-run puts the stored tags back to only
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk({abort_ff, irq, cnf_status_ff, ring_request_class_lines, claim_request_line}, 0);
    @(posedge clock);
    rst_n <= 1'b1;
    i_rqdec_far_end.load(1'b1, 2'b01, 24'h00_0100);
    #1;
    chk(abort_ff, 1'b1);
    $display("reset done");
    give_verdict();
  end
endmodule

// ---- verilog/rqdec_check.sv ----
// descriptor part order checker for one request channel
module rqdec_check (
  input wire logic [1:0] prev_tag,   // tag of previous fetched part
  input wire logic [1:0] new_tag,    // tag of part being loaded
  input wire logic [3:0] req_class,  // request class of part being loaded
  output logic bad                   // part is inconsistent
);
  logic starts;
  logic prev_closed;

  // a first or only part opens a request; last or only closes one
  always_comb begin
    starts = new_tag[1];
    prev_closed = prev_tag[0];
    bad = 1'b0;
    if (!starts && prev_closed) begin
      bad = 1'b1;
    end else if (new_tag == rqdec_pkg::RQDEC_FIRST && req_class == 4'h0) begin
      bad = 1'b1;
    end else if (new_tag == rqdec_pkg::RQDEC_FIRST && !prev_closed) begin
      bad = 1'b1;
    end
  end
endmodule

// ---- verilog/rqdec_fcdec.sv ----
// frame control byte decoder for claim and beacon requests
module rqdec_fcdec (
  input wire logic [7:0] fcb,   // frame control byte
  output logic claim,           // claim frame requested
  output logic beacon           // beacon frame requested
);
  // decoded whatever the transparency setting is
  always_comb begin
    claim = (fcb == rqdec_pkg::FCB_CLAIM);
    beacon = (fcb == rqdec_pkg::FCB_BEACON);
  end
endmodule

// ---- verilog/rqdec_pkg.sv ----
// package: descriptor field layout, part tags, register map and reset values
package rqdec_pkg;

  // ****************************************
  // descriptor field positions
  // ****************************************
  localparam int FCB_LSB = 0;        // frame control byte, word 0 bits 7..0
  localparam int RQC_LSB = 8;        // request class, word 0 bits 11..8
  localparam int CFC_LSB = 12;       // confirm class, word 0 bits 15..12
  localparam int CNT_LSB = 16;       // frame count, word 0 bits 23..16
  localparam int TAG_LSB = 30;       // part tag, word 1 bits 31..30
  localparam int CFC_DONE = 0;       // confirm on completion bit of class
  localparam int CFC_INTER = 1;      // intermediate confirm bit of class
  localparam int CFC_FULL = 2;       // full confirm select bit of class
  localparam int CFC_RPT = 3;        // repeat bit of class

  typedef enum logic [1:0] {
    RQDEC_MID = 2'b00,
    RQDEC_LAST = 2'b01,
    RQDEC_FIRST = 2'b10,
    RQDEC_ONLY = 2'b11
  } rqdec_tag_t;

  // frame control codes that call for claim or beacon frames
  localparam logic [7:0] FCB_CLAIM = 8'hc3;
  localparam logic [7:0] FCB_BEACON = 8'hc2;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADR_STAT = 8'h00;   // sticky events, write one to clear
  localparam logic [7:0] ADR_MASK = 8'h04;   // interrupt mask
  localparam logic [7:0] ADR_CTRL = 8'h08;   // transparency, ring state
  localparam logic [7:0] ADR_CLS0 = 8'h0c;   // channel 0 latched fields
  localparam logic [7:0] ADR_CLS1 = 8'h10;   // channel 1 latched fields
  localparam logic [3:0] RST_MASK = 4'h0;
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [1:0] RST_TAG = 2'b11;    // as if an only part had ended
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  // status bits: 0,1 inconsistency per channel; 2,3 unserviceable per channel
  localparam int ST_BAD = 0;
  localparam int ST_USR = 2;
endpackage

// ---- verilog/rqdec_top.sv ----
// request descriptor decoder with axi4-lite status and control registers
// Summary of operation
// - non-opening part after closed request is inconsistent
// - inconsistency aborts request, status reported
// - frame control byte used unless transparent
// - request class sampled on first/only
// - drive latched class while requesting token
// - class conflict sets unserviceable flag
// - confirm class sampled on first/only
// - bit 12 enables completion confirmation
// - bit 13 enables intermediate confirmation
// - bit 14 selects full or transmitter
// - bit 15 repeats first frame until abort; here an abort clears repeat_ff for one cycle only
// - part tag decode first/middle/last/only
// - first needs class and closed predecessor
// - word 0 bits 23..16 frame count
module rqdec_top (
  input wire logic clock,                      // system clock, 50 MHz
  input wire logic rst_n,                      // async reset, active low
  input wire logic desc_valid,                 // descriptor words loaded
  input wire logic desc_chan,                  // 0 = channel zero, 1 = channel one
  input wire logic [31:0] desc_word0,          // descriptor word 0
  input wire logic [31:0] desc_word1,          // descriptor word 1
  input wire logic token_req,                  // ring engine token request phase
  input wire logic token_chan,                 // channel requesting token
  input wire logic svc_end,                    // end of a service opportunity
  input wire logic req_done,                   // current request completed
  input wire logic [7:0] rx_fcb,               // received frame control byte
  input wire logic rx_valid,                   // received byte valid
  input wire logic [7:0] awaddr,               // axi write address
  input wire logic awvalid,                    // axi write address valid
  output logic awready,                        // axi write address ready
  input wire logic [31:0] wdata,               // axi write data
  input wire logic [3:0] wstrb,                // axi write strobes
  input wire logic wvalid,                     // axi write data valid
  output logic wready,                         // axi write data ready
  output logic [1:0] bresp,                    // axi write response
  output logic bvalid,                         // axi write response valid
  input wire logic bready,                     // axi write response ready
  input wire logic [7:0] araddr,               // axi read address
  input wire logic arvalid,                    // axi read address valid
  output logic arready,                        // axi read address ready
  output logic [31:0] rdata,                   // axi read data
  output logic [1:0] rresp,                    // axi read response
  output logic rvalid,                         // axi read valid
  input wire logic rready,                     // axi read ready
  output logic [3:0] ring_request_class_lines, // class to ring engine
  output logic claim_request_line,             // claim request
  output logic beacon_request_line,            // beacon request
  output logic [7:0] tx_fcb_ff,                // frame control byte for transmit
  output logic abort_ff,                       // request aborted, pulse
  output logic [1:0] cnf_status_ff,            // confirmation request status
  output logic cnf_write_ff,                   // write a confirmation, pulse
  output logic cnf_full_ff,                    // confirmation type full
  output logic repeat_ff,                      // repeat first frame
  output logic [7:0] frame_count_ff,           // frames in output stream
  output logic rx_match_ff,                    // received fcb matched
  output logic irq                             // interrupt, level
);
  // ****************************************
  // per-channel state and shared registers
  // ****************************************
  logic [1:0] tag_ff [2];
  logic [3:0] rqc_ff [2];
  logic [3:0] cfc_ff [2];
  logic [7:0] fcb_ff [2];
  logic [3:0] stat_ff;
  logic [3:0] mask_ff;
  logic [2:0] ctrl_ff;  // bit0 transparency, bits 2:1 ring restricted/claim state
  logic [3:0] rrcl_ff;
  logic claim_ff;
  logic beacon_ff;
  logic irq_ff;
  logic [1:0] new_tag;
  logic [3:0] new_rqc;
  logic bad;
  logic claim_d;
  logic beacon_d;
  logic usr_hit;
  logic [3:0] set_ev;
  logic [3:0] tok_cls;

  assign new_tag = desc_word1[rqdec_pkg::TAG_LSB +: 2];
  assign new_rqc = desc_word0[rqdec_pkg::RQC_LSB +: 4];

  rqdec_check u_check (
    .prev_tag(tag_ff[desc_chan]),
    .new_tag(new_tag),
    .req_class(new_rqc),
    .bad(bad)
  );

  rqdec_fcdec u_fcdec (
    .fcb(desc_word0[rqdec_pkg::FCB_LSB +: 8]),
    .claim(claim_d),
    .beacon(beacon_d)
  );

  // ****************************************
  // descriptor latching
  // ****************************************
  // tag always remembered, so a broken stream keeps being checked part by part
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        tag_ff[i] <= rqdec_pkg::RST_TAG;
        rqc_ff[i] <= 4'h0;
        cfc_ff[i] <= 4'h0;
        fcb_ff[i] <= 8'h00;
      end
    end else if (desc_valid) begin
      tag_ff[desc_chan] <= new_tag;
      if (new_tag[1] && !bad) begin
        rqc_ff[desc_chan] <= new_rqc;
        cfc_ff[desc_chan] <= desc_word0[rqdec_pkg::CFC_LSB +: 4];
        fcb_ff[desc_chan] <= desc_word0[rqdec_pkg::FCB_LSB +: 8];
      end
    end
  end

  // per-part outputs: frame count, transmit byte, claim/beacon lines
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_count_ff <= 8'h00;
      tx_fcb_ff <= 8'h00;
      claim_ff <= 1'b0;
      beacon_ff <= 1'b0;
    end else if (desc_valid && !bad) begin
      frame_count_ff <= desc_word0[rqdec_pkg::CNT_LSB +: 8];
      claim_ff <= claim_d;
      beacon_ff <= beacon_d;
      // transparent mode lets the frame data supply its own byte
      tx_fcb_ff <= ctrl_ff[0] ? 8'h00 : desc_word0[rqdec_pkg::FCB_LSB +: 8];
    end
  end

  // abort and exception status for the confirmation writer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      abort_ff <= 1'b0;
      cnf_status_ff <= 2'b00;
    end else begin
      abort_ff <= desc_valid && bad;
      if (desc_valid) begin
        cnf_status_ff <= bad ? 2'b11 : 2'b00;
      end
    end
  end

  // ****************************************
  // token request and confirmation control
  // ****************************************
  assign tok_cls = rqc_ff[token_chan];
  // restricted classes conflict with a claiming ring; restricted-only with any nonzero class
  assign usr_hit = token_req && ((ctrl_ff[1] && tok_cls[3] && tok_cls[0]) ||
                                 (ctrl_ff[2] && tok_cls != 4'h0));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rrcl_ff <= 4'h0;
    end else begin
      rrcl_ff <= token_req ? tok_cls : 4'h0;
    end
  end

  // confirmation writes; repeat follows the class repeat bit, low one cycle after an abort or a completion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnf_write_ff <= 1'b0;
      cnf_full_ff <= 1'b0;
      repeat_ff <= 1'b0;
    end else begin
      cnf_write_ff <= (req_done && cfc_ff[token_chan][rqdec_pkg::CFC_DONE]) ||
                      (svc_end && cfc_ff[token_chan][rqdec_pkg::CFC_INTER]) ||
                      (desc_valid && bad);
      cnf_full_ff <= cfc_ff[token_chan][rqdec_pkg::CFC_FULL];
      if (desc_valid && bad) begin
        repeat_ff <= 1'b0;
      end else begin
        // channel one stays idle under repeat on channel zero, host side
        repeat_ff <= cfc_ff[token_chan][rqdec_pkg::CFC_RPT] && !req_done;
      end
    end
  end

  // received frame byte compared only when not transparent
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_match_ff <= 1'b0;
    end else begin
      rx_match_ff <= rx_valid && !ctrl_ff[0] && (rx_fcb == fcb_ff[token_chan]);
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic wr_go;
  logic wr_stat;
  logic [3:0] w1c;

  assign wr_go = aw_hold && w_hold && !bvalid;
  assign wr_stat = wr_go && aw_ff == rqdec_pkg::ADR_STAT && ws_ff[0];
  assign w1c = wr_stat ? wd_ff[3:0] : 4'h0;
  assign set_ev = {usr_hit && token_chan, usr_hit && !token_chan,
                   desc_valid && bad && desc_chan, desc_valid && bad && !desc_chan};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_ff <= 8'h00;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bvalid <= 1'b0;
      bresp <= rqdec_pkg::RESP_OK;
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      // readies are flops: low once taken, high again when the response is gone
      if (awvalid && awready) begin
        awready <= 1'b0;
      end else if (!aw_hold && (!bvalid || bready)) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
      end else if (!w_hold && (!bvalid || bready)) begin
        wready <= 1'b1;
      end
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        aw_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_ff == rqdec_pkg::ADR_STAT || aw_ff == rqdec_pkg::ADR_MASK ||
                  aw_ff == rqdec_pkg::ADR_CTRL) ? rqdec_pkg::RESP_OK : rqdec_pkg::RESP_ERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // control registers; status set beats the write-one clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= 4'h0;
      mask_ff <= rqdec_pkg::RST_MASK;
      ctrl_ff <= rqdec_pkg::RST_CTRL;
    end else begin
      stat_ff <= (stat_ff & ~w1c) | set_ev;
      if (wr_go && ws_ff[0] && aw_ff == rqdec_pkg::ADR_MASK) begin
        mask_ff <= wd_ff[3:0];
      end
      if (wr_go && ws_ff[0] && aw_ff == rqdec_pkg::ADR_CTRL) begin
        ctrl_ff <= wd_ff[2:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= rqdec_pkg::RESP_OK;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= rqdec_pkg::RESP_OK;
        if (araddr == rqdec_pkg::ADR_STAT) begin
          rdata <= {28'h0, stat_ff};
        end else if (araddr == rqdec_pkg::ADR_MASK) begin
          rdata <= {28'h0, mask_ff};
        end else if (araddr == rqdec_pkg::ADR_CTRL) begin
          rdata <= {29'h0, ctrl_ff};
        end else if (araddr == rqdec_pkg::ADR_CLS0) begin
          rdata <= {14'h0, tag_ff[0], cfc_ff[0], rqc_ff[0], fcb_ff[0]};
        end else if (araddr == rqdec_pkg::ADR_CLS1) begin
          rdata <= {14'h0, tag_ff[1], cfc_ff[1], rqc_ff[1], fcb_ff[1]};
        end else begin
          rdata <= 32'h0000_0000;
          rresp <= rqdec_pkg::RESP_ERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      // a set mask bit silences its event
      irq_ff <= |(((stat_ff & ~w1c) | set_ev) & ~mask_ff);
    end
  end

  always_comb begin
    ring_request_class_lines = rrcl_ff;
    claim_request_line = claim_ff;
    beacon_request_line = beacon_ff;
    irq = irq_ff;
  end

  // ****************************************
  // checks
  // ****************************************
  sequence bad_load_s;
    desc_valid && bad;
  endsequence

  abort_follows_a: assert property (@(posedge clock) disable iff (!rst_n)
    bad_load_s |=> abort_ff && cnf_status_ff == 2'b11 && cnf_write_ff)
    else $error("inconsistent part did not abort");
  order_check_a: assert property (@(posedge clock) disable iff (!rst_n)
    desc_valid && !new_tag[1] && tag_ff[desc_chan][0] |-> bad)
    else $error("part after closed request not flagged");
  zero_class_a: assert property (@(posedge clock) disable iff (!rst_n)
    desc_valid && new_tag == rqdec_pkg::RQDEC_FIRST && new_rqc == 4'h0 |-> bad)
    else $error("first part with zero class not flagged");
  tag_kept_a: assert property (@(posedge clock) disable iff (!rst_n)
    desc_valid |=> tag_ff[$past(desc_chan)] == $past(new_tag))
    else $error("part tag not remembered");
  class_lines_a: assert property (@(posedge clock) disable iff (!rst_n)
    token_req |=> ring_request_class_lines == $past(tok_cls))
    else $error("class lines wrong during token request");
  usr_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    usr_hit |=> stat_ff[rqdec_pkg::ST_USR + $past(token_chan)])
    else $error("unserviceable flag not set");
  count_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    desc_valid && !bad |=> frame_count_ff == $past(desc_word0[23:16]))
    else $error("frame count not loaded");
  middle_keeps_a: assert property (@(posedge clock) disable iff (!rst_n)
    desc_valid && !new_tag[1] |=> rqc_ff[$past(desc_chan)] == $past(rqc_ff[desc_chan]))
    else $error("class resampled on non-opening part");
  done_cnf_a: assert property (@(posedge clock) disable iff (!rst_n)
    req_done && cfc_ff[token_chan][0] |=> cnf_write_ff)
    else $error("completion confirmation missing");
endmodule
